// File: addr_map_pkg.sv
// constants for the data address and memory map block
package addr_map_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int PAGE_W = 9;
   localparam int OFFS_W = 7;
   localparam int NUM_AUX = 5;
   localparam int PAGES = 512;
   localparam int PAGE_WORDS = 128;
   // on-chip block bases; block zero is data or program
   localparam logic [15:0] CFG_DATA_BASE = 16'h0200;
   localparam logic [15:0] CFG_PROG_BASE = 16'hFF00;
   localparam logic [15:0] FIXED_ONE_BASE = 16'h0300;
   localparam logic [15:0] FIXED_TWO_BASE = 16'h0060;
   localparam int CFG_WORDS = 256;
   localparam int FIXED_ONE_WORDS = 256;
   localparam int FIXED_TWO_WORDS = 32;
   localparam int TOTAL_WORDS = 544;
   // memory-mapped peripheral registers in data space
   localparam logic [15:0] SERIAL_RX_ADDR = 16'h0000;
   localparam logic [15:0] SERIAL_TX_ADDR = 16'h0001;
   localparam logic [15:0] TIMER_COUNT_ADDR = 16'h0002;
   localparam logic [15:0] TIMER_PERIOD_ADDR = 16'h0003;
   localparam logic [15:0] INT_MASK_ADDR = 16'h0004;
   localparam logic [15:0] GLOBAL_SIZE_ADDR = 16'h0005;
   localparam logic [7:0] GLOBAL_SIZE_RESET = 8'h00;
   // address modes
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_INDIRECT = 2'h1;
   localparam logic [1:0] MODE_IMMEDIATE = 2'h2;
   // indirect update kinds
   localparam logic [2:0] UPD_NONE = 3'h0;
   localparam logic [2:0] UPD_INC = 3'h1;
   localparam logic [2:0] UPD_DEC = 3'h2;
   localparam logic [2:0] UPD_ADD0 = 3'h3;
   localparam logic [2:0] UPD_SUB0 = 3'h4;
   // address spaces
   localparam logic [1:0] SPACE_PROG = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACCESS = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_HOLD = 4'b1000
   } bus_state_type;
endpackage

// File: addr_map.sv
// data address generation, memory map and external bus control
`timescale 1ns/1ps
module addr_map (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire logic [1:0] REQ_MODE,
   input wire logic [1:0] REQ_SPACE,
   input wire logic REQ_WRITE,
   input wire logic [6:0] REQ_OFFSET,
   input wire logic [15:0] REQ_IMMEDIATE,
   input wire logic [15:0] REQ_PROG_ADDR,
   input wire logic [2:0] REQ_UPDATE,
   input wire logic REQ_LOAD_PTR,
   input wire logic [2:0] REQ_NEW_PTR,
   input wire logic REQ_LOAD_PAGE,
   input wire logic [8:0] REQ_NEW_PAGE,
   input wire logic REQ_LOAD_AUX,
   input wire logic [15:0] REQ_AUX_VALUE,
   input wire logic [15:0] REQ_WDATA,
   input wire logic CFG_AS_DATA,
   input wire logic CFG_AS_PROG,
   output logic REQ_DONE,
   output logic [15:0] RESULT_ADDR,
   output logic [15:0] RESULT_DATA,
   output logic ONCHIP_SEL,
   output logic PERIPH_SEL,
   output logic CFG_IS_PROG,
   output logic [2:0] AUX_PTR,
   output logic [7:0] GLOBAL_SIZE,
   output logic [15:0] EXT_ADDR,
   output logic EXT_ADDR_OE_N,
   output logic [15:0] EXT_DATA_OUT,
   input wire logic [15:0] EXT_DATA_IN,
   output logic EXT_DATA_OE_N,
   output logic PROG_SEL_N,
   output logic DATA_SEL_N,
   output logic IO_SEL_N,
   output logic READ_WRITE_N,
   output logic STROBE_N,
   output logic CTRL_OE_N,
   input wire logic READY,
   input wire logic HOLD_N,
   output logic BUS_HOLD_GRANT_N,
   output logic GLOBAL_BUS_REQUEST_N
);
   logic ready_s1_q, ready_q, hold_s1_q, hold_n_q;
   logic [15:0] aux_address_regs_q [0:addr_map_pkg::NUM_AUX-1];
   logic [2:0] aux_reg_pointer_q;
   logic [8:0] page_q;
   logic cfg_prog_q;
   logic [7:0] global_region_size_q;
   addr_map_pkg::bus_state_type state_q;
   logic [15:0] addr_d, xaddr_q, wdata_q, rdata_q, done_addr_q;
   logic xwrite_q, done_q;
   logic [1:0] xspace_q;
   logic onchip, periph, is_global, ext_need, take;

   // pins cross from outside, so two flops before use
   always_ff @(posedge MCLK) begin
      ready_s1_q <= RST ? 1'b0 : READY;
      ready_q <= RST ? 1'b0 : ready_s1_q;
      hold_s1_q <= RST ? 1'b1 : HOLD_N;
      hold_n_q <= RST ? 1'b1 : hold_s1_q;
   end

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] base,
                                     input int words);
      in_range = (a >= base) && ({16'h0000, a} < {16'h0000, base} + 32'(words));
   endfunction

   // immediate mode in data space never reaches memory; it just returns the field
   always_comb begin
      addr_d = {page_q, REQ_OFFSET};
      case (REQ_MODE)
         addr_map_pkg::MODE_INDIRECT: addr_d = aux_address_regs_q[aux_reg_pointer_q];
         addr_map_pkg::MODE_IMMEDIATE: addr_d = REQ_IMMEDIATE;
         default: addr_d = {page_q, REQ_OFFSET};
      endcase
      if (REQ_SPACE != addr_map_pkg::SPACE_DATA) addr_d = REQ_PROG_ADDR;
   end

   always_comb begin
      onchip = 1'b0;
      periph = 1'b0;
      if (REQ_SPACE == addr_map_pkg::SPACE_DATA) begin
         onchip = in_range(addr_d, addr_map_pkg::FIXED_ONE_BASE, addr_map_pkg::FIXED_ONE_WORDS)
            || in_range(addr_d, addr_map_pkg::FIXED_TWO_BASE, addr_map_pkg::FIXED_TWO_WORDS)
            || (!cfg_prog_q
                && in_range(addr_d, addr_map_pkg::CFG_DATA_BASE, addr_map_pkg::CFG_WORDS));
         periph = addr_d <= addr_map_pkg::GLOBAL_SIZE_ADDR;
      end else if (REQ_SPACE == addr_map_pkg::SPACE_PROG) begin
         onchip = cfg_prog_q
            && in_range(addr_d, addr_map_pkg::CFG_PROG_BASE, addr_map_pkg::CFG_WORDS);
      end
   end

   // global region is the top of data space, sized by high-byte mask
   assign is_global = (REQ_SPACE == addr_map_pkg::SPACE_DATA) && !onchip && !periph
      && (global_region_size_q != 8'h00)
      && ((addr_d[15:8] & global_region_size_q) == global_region_size_q);
   assign ext_need = !onchip && !periph && (REQ_MODE != addr_map_pkg::MODE_IMMEDIATE
      || REQ_SPACE != addr_map_pkg::SPACE_DATA);
   assign take = REQ_VALID && state_q == addr_map_pkg::ST_IDLE && hold_n_q;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_q <= addr_map_pkg::ST_IDLE;
      end else begin
         case (state_q)
            addr_map_pkg::ST_IDLE: begin
               if (!hold_n_q) state_q <= addr_map_pkg::ST_HOLD;
               else if (take && ext_need) state_q <= addr_map_pkg::ST_ACCESS;
            end
            addr_map_pkg::ST_ACCESS: begin
               // fast memory answers in the first cycle with no wait state
               if (ready_q) state_q <= addr_map_pkg::ST_IDLE;
               else state_q <= addr_map_pkg::ST_WAIT;
            end
            addr_map_pkg::ST_WAIT: if (ready_q) state_q <= addr_map_pkg::ST_IDLE;
            addr_map_pkg::ST_HOLD: if (hold_n_q) state_q <= addr_map_pkg::ST_IDLE;
            default: state_q <= addr_map_pkg::ST_IDLE;
         endcase
      end
   end

   // a hold arriving mid-transfer waits for the transfer to finish
   always_ff @(posedge MCLK) begin
      if (RST) begin
         xaddr_q <= 16'h0000;
         xspace_q <= addr_map_pkg::SPACE_DATA;
         xwrite_q <= 1'b0;
         wdata_q <= 16'h0000;
         GLOBAL_BUS_REQUEST_N <= 1'b1;
      end else if (take && ext_need) begin
         xaddr_q <= addr_d;
         xspace_q <= REQ_SPACE;
         xwrite_q <= REQ_WRITE;
         wdata_q <= REQ_WDATA;
         GLOBAL_BUS_REQUEST_N <= !is_global;
      end else if (state_q == addr_map_pkg::ST_IDLE) begin
         GLOBAL_BUS_REQUEST_N <= 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         done_q <= 1'b0;
         rdata_q <= 16'h0000;
         done_addr_q <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         if (take && !ext_need) begin
            done_q <= 1'b1;
            done_addr_q <= addr_d;
            rdata_q <= REQ_MODE == addr_map_pkg::MODE_IMMEDIATE ? REQ_IMMEDIATE
               : (addr_d == addr_map_pkg::GLOBAL_SIZE_ADDR ? {8'h00, global_region_size_q}
               : 16'h0000);
         end else if ((state_q == addr_map_pkg::ST_ACCESS
                       || state_q == addr_map_pkg::ST_WAIT) && ready_q) begin
            done_q <= 1'b1;
            done_addr_q <= xaddr_q;
            rdata_q <= xwrite_q ? wdata_q : EXT_DATA_IN;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         aux_reg_pointer_q <= 3'h0;
         for (int i = 0; i < addr_map_pkg::NUM_AUX; i++) aux_address_regs_q[i] <= 16'h0000;
      end else if (take) begin
         if (REQ_LOAD_AUX) begin
            aux_address_regs_q[aux_reg_pointer_q] <= REQ_AUX_VALUE;
         end else if (REQ_MODE == addr_map_pkg::MODE_INDIRECT) begin
            case (REQ_UPDATE)
               addr_map_pkg::UPD_INC: aux_address_regs_q[aux_reg_pointer_q] <=
                  aux_address_regs_q[aux_reg_pointer_q] + 16'h0001;
               addr_map_pkg::UPD_DEC: aux_address_regs_q[aux_reg_pointer_q] <=
                  aux_address_regs_q[aux_reg_pointer_q] - 16'h0001;
               addr_map_pkg::UPD_ADD0: aux_address_regs_q[aux_reg_pointer_q] <=
                  aux_address_regs_q[aux_reg_pointer_q] + aux_address_regs_q[0];
               addr_map_pkg::UPD_SUB0: aux_address_regs_q[aux_reg_pointer_q] <=
                  aux_address_regs_q[aux_reg_pointer_q] - aux_address_regs_q[0];
               default: ;
            endcase
         end
         if (REQ_LOAD_PTR && REQ_NEW_PTR < 3'(addr_map_pkg::NUM_AUX))
            aux_reg_pointer_q <= REQ_NEW_PTR;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         cfg_prog_q <= 1'b0;
         page_q <= 9'h000;
         global_region_size_q <= addr_map_pkg::GLOBAL_SIZE_RESET;
      end else begin
         if (CFG_AS_PROG) cfg_prog_q <= 1'b1;
         else if (CFG_AS_DATA) cfg_prog_q <= 1'b0;
         if (take && REQ_LOAD_PAGE) page_q <= REQ_NEW_PAGE;
         if (take && REQ_WRITE && REQ_SPACE == addr_map_pkg::SPACE_DATA
             && REQ_MODE != addr_map_pkg::MODE_IMMEDIATE
             && addr_d == addr_map_pkg::GLOBAL_SIZE_ADDR)
            global_region_size_q <= REQ_WDATA[7:0];
      end
   end

   logic busy;
   assign busy = state_q == addr_map_pkg::ST_ACCESS || state_q == addr_map_pkg::ST_WAIT;
   assign REQ_DONE = done_q;
   assign RESULT_ADDR = done_addr_q;
   assign RESULT_DATA = rdata_q;
   assign ONCHIP_SEL = onchip;
   assign PERIPH_SEL = periph;
   assign CFG_IS_PROG = cfg_prog_q;
   assign AUX_PTR = aux_reg_pointer_q;
   assign GLOBAL_SIZE = global_region_size_q;
   assign EXT_ADDR = xaddr_q;
   assign EXT_DATA_OUT = wdata_q;
   assign CTRL_OE_N = state_q == addr_map_pkg::ST_HOLD;
   assign EXT_ADDR_OE_N = state_q == addr_map_pkg::ST_HOLD;
   assign EXT_DATA_OE_N = !(busy && xwrite_q);
   assign BUS_HOLD_GRANT_N = state_q != addr_map_pkg::ST_HOLD;
   assign STROBE_N = !busy;
   assign READ_WRITE_N = !(busy && xwrite_q);
   assign PROG_SEL_N = !(busy && xspace_q == addr_map_pkg::SPACE_PROG);
   assign DATA_SEL_N = !(busy && xspace_q == addr_map_pkg::SPACE_DATA);
   assign IO_SEL_N = !(busy && xspace_q == addr_map_pkg::SPACE_IO);

   hold_floats_a: assert property (@(posedge MCLK) disable iff (RST)
      !hold_n_q && state_q == addr_map_pkg::ST_IDLE |=> !BUS_HOLD_GRANT_N && CTRL_OE_N)
      else $error("hold not granted");
   hold_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
      !BUS_HOLD_GRANT_N |-> STROBE_N) else $error("bus active in hold");
   sequence wait_seq;
      busy && !ready_q;
   endsequence
   ready_waits_a: assert property (@(posedge MCLK) disable iff (RST)
      wait_seq |=> !STROBE_N) else $error("cycle ended without ready");
   fast_access_a: assert property (@(posedge MCLK) disable iff (RST)
      state_q == addr_map_pkg::ST_ACCESS && ready_q |=> REQ_DONE && STROBE_N)
      else $error("wait inserted");
   global_req_a: assert property (@(posedge MCLK) disable iff (RST)
      take && ext_need && is_global |=> !GLOBAL_BUS_REQUEST_N)
      else $error("global request missing");
   global_drop_a: assert property (@(posedge MCLK) disable iff (RST)
      state_q == addr_map_pkg::ST_IDLE && !take |=> GLOBAL_BUS_REQUEST_N)
      else $error("global request stuck");
   direct_addr_a: assert property (@(posedge MCLK) disable iff (RST)
      take && !ext_need && REQ_MODE == addr_map_pkg::MODE_DIRECT
      && REQ_SPACE == addr_map_pkg::SPACE_DATA |=> RESULT_ADDR == {$past(page_q), $past(REQ_OFFSET)})
      else $error("direct address wrong");
   aux_inc_a: assert property (@(posedge MCLK) disable iff (RST)
      take && !REQ_LOAD_AUX && REQ_MODE == addr_map_pkg::MODE_INDIRECT
      && REQ_UPDATE == addr_map_pkg::UPD_INC
      |=> aux_address_regs_q[$past(aux_reg_pointer_q)] == $past(addr_d) + 16'h0001)
      else $error("increment wrong");
   ptr_range_a: assert property (@(posedge MCLK) disable iff (RST)
      aux_reg_pointer_q < 3'h5) else $error("pointer out of range");
   cfg_switch_a: assert property (@(posedge MCLK) disable iff (RST)
      CFG_AS_PROG |=> CFG_IS_PROG) else $error("config not switched");
endmodule // addr_map

// File: ext_bus_model.sv
// behavioural external memory and I/O space answering the block's bus cycles
`timescale 1ns/1ps
module ext_bus_model (
   input wire logic MCLK,
   input wire logic [15:0] EXT_ADDR,
   input wire logic [15:0] EXT_DATA_OUT,
   input wire logic STROBE_N,
   input wire logic READ_WRITE_N,
   input wire logic [3:0] WAITS,
   output logic [15:0] EXT_DATA_IN,
   output logic READY
);
   logic [15:0] mem_q [0:15];
   // start from a known level so the released bus really toggles instead of staying unknown
   logic [15:0] last_q = 16'h0000;
   logic [3:0] cnt_q;
   // ready held low until the programmed wait count runs out
   always_ff @(posedge MCLK) begin
      if (STROBE_N) begin
         cnt_q <= 4'h0;
         READY <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == WAITS) ? cnt_q : cnt_q + 4'h1;
         READY <= (cnt_q == WAITS);
      end
   end
   // only four address bits decode, so the model aliases every 16 words
   always_ff @(posedge MCLK) begin
      if (!STROBE_N && !READ_WRITE_N) begin
         mem_q[EXT_ADDR[3:0]] <= EXT_DATA_OUT;
      end
      last_q <= EXT_DATA_IN;
   end
   // a released bus toggles every cycle so a stale value never passes
   assign EXT_DATA_IN = (!STROBE_N && READ_WRITE_N) ? mem_q[EXT_ADDR[3:0]] : ~last_q;
endmodule // ext_bus_model

// File: data_address_memory_map_tb.sv
// self-checking bench for the data address and memory map block
`timescale 1ns/1ps
module data_address_memory_map_tb;
   logic MCLK, RST, REQ_VALID, REQ_WRITE, REQ_LOAD_PTR, REQ_LOAD_PAGE, REQ_LOAD_AUX;
   logic CFG_AS_DATA, CFG_AS_PROG, READY, HOLD_N, REQ_DONE, ONCHIP_SEL, PERIPH_SEL;
   logic CFG_IS_PROG, EXT_ADDR_OE_N, EXT_DATA_OE_N, PROG_SEL_N, DATA_SEL_N, IO_SEL_N;
   logic READ_WRITE_N, STROBE_N, CTRL_OE_N, BUS_HOLD_GRANT_N, GLOBAL_BUS_REQUEST_N;
   logic [1:0] REQ_MODE, REQ_SPACE;
   logic [6:0] REQ_OFFSET;
   logic [2:0] REQ_UPDATE, REQ_NEW_PTR, AUX_PTR, sel_seen;
   logic [8:0] REQ_NEW_PAGE;
   logic [7:0] GLOBAL_SIZE;
   logic [3:0] WAITS;
   logic [15:0] REQ_IMMEDIATE, REQ_PROG_ADDR, REQ_AUX_VALUE, REQ_WDATA, EXT_DATA_IN;
   logic [15:0] RESULT_ADDR, RESULT_DATA, EXT_ADDR, EXT_DATA_OUT, addr_seen, v;
   logic [15:0] aux [0:4];
   logic [31:0] lfsr_q;
   logic ext_seen, br_seen;
   int error_cnt, cmp_count, n;
   addr_map dut (.*);
   ext_bus_model partner (.*);
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   function automatic logic [15:0] nxt(input logic [15:0] a, input logic [2:0] u);
      case (u)
         addr_map_pkg::UPD_INC: return a + 16'h0001;
         addr_map_pkg::UPD_DEC: return a - 16'h0001;
         addr_map_pkg::UPD_ADD0: return a + aux[0];
         addr_map_pkg::UPD_SUB0: return a - aux[0];
         default: return a;
      endcase
   endfunction
   task automatic rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      v = lfsr_q[15:0];
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one request: fields change after an edge, valid drops at the taking edge
   task automatic issue(input logic [1:0] md, sp, input logic wr, input logic [15:0] val,
                        input logic [2:0] up, fl, ptr);
      {REQ_MODE, REQ_SPACE, REQ_WRITE, REQ_UPDATE, REQ_NEW_PTR} <= {md, sp, wr, up, ptr};
      {REQ_OFFSET, REQ_NEW_PAGE} <= {val[6:0], val[15:7]};
      {REQ_IMMEDIATE, REQ_PROG_ADDR, REQ_AUX_VALUE} <= {3{val}};
      REQ_WDATA <= val ^ 16'h00C5;
      {REQ_LOAD_AUX, REQ_LOAD_PAGE, REQ_LOAD_PTR} <= fl;
      WAITS <= lfsr_q[3:0];
      REQ_VALID <= 1'b1;
      ext_seen = 1'b0;
      br_seen = 1'b0;
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
      for (n = 0; n < 200; n++) begin
         @(negedge MCLK);
         if (STROBE_N === 1'b0) begin
            ext_seen = 1'b1;
            sel_seen = {PROG_SEL_N, DATA_SEL_N, IO_SEL_N};
            addr_seen = EXT_ADDR;
         end
         br_seen = br_seen | (GLOBAL_BUS_REQUEST_N === 1'b0);
         if (REQ_DONE === 1'b1) break;
      end
      if (n == 200) begin
         error_cnt++;
         results();
      end
      @(posedge MCLK);
   endtask
   task automatic imm(input logic [15:0] val, input logic [2:0] fl, ptr);
      issue(addr_map_pkg::MODE_IMMEDIATE, addr_map_pkg::SPACE_DATA, 1'b0, val, 3'h0, fl, ptr);
   endtask
   task automatic acc(input logic [1:0] sp, input logic wr, input logic [15:0] val);
      issue(addr_map_pkg::MODE_DIRECT, sp, wr, val, 3'h0, 3'h0, 3'h0);
   endtask
   task automatic ind(input logic [15:0] val, input logic [2:0] up, fl, ptr);
      issue(addr_map_pkg::MODE_INDIRECT, addr_map_pkg::SPACE_DATA, 1'b0, val, up, fl, ptr);
   endtask
   initial begin
      {REQ_VALID, REQ_WRITE, REQ_LOAD_PTR, REQ_LOAD_PAGE, REQ_LOAD_AUX, CFG_AS_DATA} = '0;
      {CFG_AS_PROG, REQ_MODE, REQ_SPACE, REQ_OFFSET, REQ_UPDATE, REQ_NEW_PTR} = '0;
      {REQ_NEW_PAGE, REQ_IMMEDIATE, REQ_PROG_ADDR, REQ_AUX_VALUE, REQ_WDATA} = '0;
      {RST, HOLD_N, WAITS} = 6'h30;
      {lfsr_q, error_cnt, cmp_count} = {32'h35CE, 32'h0, 32'h0};
      // three edges so the hold and ready synchronisers are flushed too
      repeat (3) @(posedge MCLK);
      RST <= 1'b0;
      @(negedge MCLK);
      chk("size", 16'h0000, GLOBAL_SIZE);
      chk("pointer", 16'h0000, AUX_PTR);
      chk("block", 16'h0000, CFG_IS_PROG);
      chk("grant", 16'h0001, BUS_HOLD_GRANT_N);
      chk("request", 16'h0001, GLOBAL_BUS_REQUEST_N);
      @(posedge MCLK);
      for (int k = 0; k < 8; k++) begin
         rnd();
         v = v | 16'h0400;
         imm(v, 3'h2, 3'h0);
         chk("immediate", v, RESULT_DATA);
         chk("immediate bus", 16'h0000, ext_seen);
         acc(addr_map_pkg::SPACE_DATA, 1'b0, v);
         chk("direct", v, RESULT_ADDR);
         chk("bus address", v, addr_seen);
         chk("selects", 16'h0005, sel_seen);
      end
      for (int i = 0; i < 5; i++) begin
         imm(16'h0000, 3'h1, i[2:0]);
         chk("pointer", i[15:0], AUX_PTR);
         rnd();
         aux[i] = v | 16'h0400;
         ind(aux[i], 3'h0, 3'h4, 3'h0);
         for (int u = 0; u < 5; u++) begin
            ind(16'h0000, u[2:0], 3'h0, 3'h0);
            chk("indirect", aux[i], RESULT_ADDR);
            aux[i] = nxt(aux[i], u[2:0]);
         end
         imm(16'h0000, 3'h1, 3'h7);
         chk("bad pointer", i[15:0], AUX_PTR);
      end
      // pointer loads land after the old register is used and updated
      for (int i = 0; i < 5; i++) begin
         ind(16'h0000, addr_map_pkg::UPD_INC, 3'h1, i[2:0]);
         chk("post load", aux[(i + 4) % 5], RESULT_ADDR);
         aux[(i + 4) % 5] = aux[(i + 4) % 5] + 16'h0001;
      end
      imm(16'h0000, 3'h2, 3'h0);
      acc(addr_map_pkg::SPACE_DATA, 1'b1, 16'h0005);
      chk("size", 16'h00C0, GLOBAL_SIZE);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'h0005);
      chk("size read", 16'h00C0, RESULT_DATA);
      imm(16'hC400, 3'h2, 3'h0);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'hC400);
      chk("global", 16'h0001, br_seen);
      // the request drops on the edge that ended the task, so look after it settles
      @(negedge MCLK);
      chk("released", 16'h0001, GLOBAL_BUS_REQUEST_N);
      imm(16'h8400, 3'h2, 3'h0);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'h8400);
      chk("local", 16'h0000, br_seen);
      imm(16'h0210, 3'h2, 3'h0);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'h0210);
      chk("block data", 16'h0000, ext_seen);
      CFG_AS_PROG <= 1'b1;
      @(posedge MCLK);
      CFG_AS_PROG <= 1'b0;
      @(posedge MCLK);
      chk("block prog", 16'h0001, CFG_IS_PROG);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'h0210);
      chk("block moved", 16'h0001, ext_seen);
      imm(16'h0310, 3'h2, 3'h0);
      acc(addr_map_pkg::SPACE_DATA, 1'b0, 16'h0310);
      chk("fixed block", 16'h0000, ext_seen);
      acc(addr_map_pkg::SPACE_PROG, 1'b0, 16'hFF10);
      chk("program ram", 16'h0000, ext_seen);
      acc(addr_map_pkg::SPACE_PROG, 1'b0, 16'h1234);
      chk("program select", 16'h0003, sel_seen);
      chk("program address", 16'h1234, addr_seen);
      CFG_AS_DATA <= 1'b1;
      @(posedge MCLK);
      CFG_AS_DATA <= 1'b0;
      @(posedge MCLK);
      chk("block back", 16'h0000, CFG_IS_PROG);
      for (int k = 0; k < 4; k++) begin
         rnd();
         v = {v[15:4], k[3:0]};
         acc(addr_map_pkg::SPACE_IO, 1'b1, v);
         chk("io select", 16'h0006, sel_seen);
         acc(addr_map_pkg::SPACE_IO, 1'b0, v);
         chk("io data", v ^ 16'h00C5, RESULT_DATA);
      end
      HOLD_N <= 1'b0;
      for (n = 0; n < 20 && BUS_HOLD_GRANT_N !== 1'b0; n++) @(negedge MCLK);
      chk("grant", 16'h0000, BUS_HOLD_GRANT_N);
      chk("float", 16'h0007, {CTRL_OE_N, EXT_ADDR_OE_N, EXT_DATA_OE_N});
      @(posedge MCLK);
      REQ_VALID <= 1'b1;
      br_seen = 1'b0;
      repeat (6) begin
         @(negedge MCLK);
         br_seen = br_seen | (REQ_DONE !== 1'b0) | (STROBE_N !== 1'b1);
      end
      chk("idle in hold", 16'h0000, br_seen);
      @(posedge MCLK);
      {REQ_VALID, HOLD_N} <= 2'h1;
      for (n = 0; n < 20 && BUS_HOLD_GRANT_N !== 1'b1; n++) @(negedge MCLK);
      chk("grant off", 16'h0001, BUS_HOLD_GRANT_N);
      @(posedge MCLK);
      imm(16'hA5A5, 3'h0, 3'h0);
      chk("after hold", 16'hA5A5, RESULT_DATA);
      results();
   end
endmodule // data_address_memory_map_tb
